// *** bell_pkg.sv ***
package bell_pkg;
    localparam int          NCH           = 16;
    localparam int          CLK_NS        = 4;
    localparam int          CLK_MHZ       = 250;
    localparam int          US_STEP       = 8;
    localparam int          US_TICK_CYC   = US_STEP * CLK_MHZ;
    localparam int          MS_NS         = 1_000_000;
    localparam int          MS_TICK_CYC   = MS_NS / CLK_NS;
    localparam int          RX_TIMEOUT_MS = 1000;
    localparam int          RX_TIMEOUT_CYC = RX_TIMEOUT_MS * MS_TICK_CYC;
    localparam logic [7:0]  DEBOUNCE_MS_RST = 8'h02;
    localparam logic [7:0]  GUARD_CS_RST  = 8'h0A;
    localparam logic [3:0]  FLAGS_RST     = 4'h1;
    localparam int          FLAG_PULSE    = 0;
    localparam int          FLAG_MISFIRE  = 1;
    localparam int          FLAG_DEBOUNCE = 2;
    localparam int          FLAG_LED      = 3;
    localparam logic [3:0]  RX_SET_LAST   = 4'hC;
    localparam logic [7:0]  HOST_QUERY    = 8'hFD;
    localparam logic [7:0]  HOST_IGNORE   = 8'hFE;
    localparam logic [7:0]  DELAY_TERM    = 8'hFF;
    localparam logic [7:0]  KIND_S        = 8'h53;
    localparam logic [7:0]  KIND_M        = 8'h4D;
    localparam logic [7:0]  KIND_D        = 8'h44;
    localparam int          FIFO_W        = 8;
    localparam int          FIFO_D        = 16;
    localparam logic [127:0] CHAR_MAP     = 128'h44434241544530393837363534333231;

    typedef enum logic [2:0] {
        ST_WAIT  = 3'b000,
        ST_DEB   = 3'b001,
        ST_GUARD = 3'b010,
        ST_DIS   = 3'b011
    } chan_state_t;

    typedef enum logic [0:0] {
        RX_IDLE = 1'b0,
        RX_COLL = 1'b1
    } rx_state_t;
endpackage

// *** bell_sensor_scanner.sv ***
`timescale 1ns/1ns
// Function
// - Waiting channel seeing a high-to-low edge arms debounce expiry and enters debounce.
// - Debounce expired with input still low sends the channel character, enters guard.
// - Guard state holds until the guard expiry is reached, then waits for input.
// - Guard period defaults to ten centiseconds and is set by configuration.
// - Input level is ignored for normal operation while in guard.
// - Disabled channels do nothing; enable comes from start-up config or a command.
// - Each pass scans channels up to the highest enabled one, sixteen at most.
// - Test mode ignores sensors, emits test characters, lasts until reset.
// - Free-running 32-bit timers; far-future debounce expiry counts as wrapped.
// - Pulse accepted only if low for the debounce period, else misfire to waiting.
// - Debounce set in milliseconds, checked against an 8 microsecond resolution counter.
// - Each accepted pulse sends one character from 1-9,0,E,T,A,B,C,D.
// - Debug mask loads from storage one edge after reset; saved only on save while debugging.
// - Debug mode suppresses normal character output on every channel.
// - Pulse-timer flag reports channel, character, guard expiry, S, length, count.
// - First pulse still active at guard expiry reports zero length.
// - Misfire flag reports channel, character, debounce expiry, M, pulse length.
// - Debounce flag reports channel, character, debounce expiry and D.
// - Indicator shows channel 1 pulses, or all debug channels with its flag.
// - Reset: debug off, only pulse-timer flag, mask from storage; kept when disabled.
// - First byte host query gets the query echoed; other host commands are dropped.
// - Otherwise collect thirteen bytes within one second; a full set ending in the delay terminator is discarded.
// - Incomplete or badly terminated set passes only its first byte to the interpreter.
// - Indicator signals each passed configuration command and each command error.

////////////////////////////////////////////////////////////////////////////////
module byte_fifo #(
    parameter int W  = 8,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    wire push = ce && in_valid && in_ready;
    wire pop  = ce && out_valid && out_ready;

    assign in_ready  = cnt_reg != (AW+1)'(D);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem[rd_reg];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_reg + AW'(push);
            rd_reg  <= rd_reg + AW'(pop);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module bell_sensor_scanner #(
    parameter int MS_CYC  = bell_pkg::MS_TICK_CYC,
    parameter int RXT_CYC = bell_pkg::RX_TIMEOUT_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [15:0] sensor_n,
    input  wire logic [15:0] nv_enable,
    input  wire logic [15:0] nv_mask,
    input  wire logic        cfg_we,
    input  wire logic [7:0]  cfg_debounce_ms,
    input  wire logic [7:0]  cfg_guard_cs,
    input  wire logic [15:0] cfg_enable,
    input  wire logic        cfg_debug_mode,
    input  wire logic [3:0]  cfg_flags,
    input  wire logic [15:0] cfg_mask,
    input  wire logic        test_cmd,
    input  wire logic        save_cmd,
    input  wire logic        cmd_error,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready,
    output logic             cmd_valid,
    output logic [7:0]       cmd_byte,
    output logic             nv_save,
    output logic [15:0]      nv_mask_out,
    output logic             indicator,
    output logic             dbg_valid,
    output logic [7:0]       dbg_kind,
    output logic [4:0]       dbg_chan,
    output logic [7:0]       dbg_char,
    output logic [31:0]      dbg_time,
    output logic [31:0]      dbg_len,
    output logic [7:0]       dbg_count
);
    function automatic logic [7:0] map_char(input logic [3:0] ch);
        map_char = bell_pkg::CHAR_MAP[{ch, 3'b000} +: 8];
    endfunction

    function automatic logic [3:0] top_chan(input logic [15:0] en);
        top_chan = 4'h0;
        for (int i = 0; i < bell_pkg::NCH; i++) begin
            if (en[i]) top_chan = 4'(i);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage sensor synchronisers; a level changes once stages two and three agree.
    logic [15:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg  <= 16'hFFFF;
            s2_reg  <= 16'hFFFF;
            s3_reg  <= 16'hFFFF;
            lvl_reg <= 16'hFFFF;
        end else if (ce) begin
            s1_reg <= sensor_n;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < bell_pkg::NCH; i++) begin
                if (s2_reg[i] == s3_reg[i]) lvl_reg[i] <= s3_reg[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Free-running microsecond (8 us steps) and millisecond counters.
    logic [31:0] us_reg, ms_reg, uc_reg, mc_reg;
    wire         us_tick = uc_reg == 32'(bell_pkg::US_TICK_CYC - 1);
    wire         ms_tick = mc_reg == 32'(MS_CYC - 1);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            us_reg <= '0;
            ms_reg <= '0;
            uc_reg <= '0;
            mc_reg <= '0;
        end else if (ce) begin
            uc_reg <= us_tick ? '0 : uc_reg + 32'h1;
            mc_reg <= ms_tick ? '0 : mc_reg + 32'h1;
            us_reg <= us_reg + (us_tick ? 32'(bell_pkg::US_STEP) : 32'h0);
            ms_reg <= ms_reg + 32'(ms_tick);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and debug settings; storage values load one edge after reset.
    logic        init_reg, dbgm_reg, test_reg;
    logic [7:0]  deb_ms_reg, guard_cs_reg;
    logic [15:0] en_reg, mask_reg;
    logic [3:0]  flags_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            init_reg     <= 1'b0;
            dbgm_reg     <= 1'b0;
            flags_reg    <= bell_pkg::FLAGS_RST;
            deb_ms_reg   <= bell_pkg::DEBOUNCE_MS_RST;
            guard_cs_reg <= bell_pkg::GUARD_CS_RST;
            en_reg       <= 16'hFFFF;
            mask_reg     <= 16'hFFFF;
            test_reg     <= 1'b0;
        end else if (ce) begin
            init_reg <= 1'b1;
            test_reg <= test_reg | test_cmd;
            if (!init_reg) begin
                en_reg   <= nv_enable;
                mask_reg <= nv_mask;
            end else if (cfg_we) begin
                deb_ms_reg   <= cfg_debounce_ms;
                guard_cs_reg <= cfg_guard_cs;
                en_reg       <= cfg_enable;
                dbgm_reg     <= cfg_debug_mode;
                flags_reg    <= cfg_flags;
                mask_reg     <= cfg_mask;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel scanner.
    bell_pkg::chan_state_t st_reg [16];
    logic [31:0] exp_reg [16], start_reg [16], end_reg [16];
    logic [7:0]  cnt_reg [16];
    logic [15:0] prev_reg, ended_reg;
    logic [3:0]  idx_reg;
    logic        reply_reg, tp_reg;
    logic [3:0]  tp_idx_reg;
    logic        fin_ready;

    wire [31:0] deb_us    = 32'(deb_ms_reg) * 32'd1000;
    wire [31:0] guard_ms  = 32'(guard_cs_reg) * 32'd10;
    wire [3:0]  top       = top_chan(en_reg);
    wire        step      = ce && init_reg && fin_ready && !reply_reg && !test_reg;
    wire        lvl       = lvl_reg[idx_reg];
    wire        fall      = prev_reg[idx_reg] && !lvl;
    wire [31:0] exp_cur   = exp_reg[idx_reg];
    wire [31:0] rem_us    = exp_cur - us_reg;
    wire        deb_done  = rem_us == '0 || rem_us[31] || rem_us > deb_us;
    wire [31:0] since_ms  = ms_reg - exp_cur;
    wire        guard_done = !since_ms[31];
    wire bell_pkg::chan_state_t cur = st_reg[idx_reg];
    wire        on        = en_reg[idx_reg];
    wire        accept    = on && cur == bell_pkg::ST_DEB && !lvl && deb_done;
    wire        misfire   = on && cur == bell_pkg::ST_DEB && lvl;
    wire        g_exit    = on && cur == bell_pkg::ST_GUARD && guard_done;
    wire        dsel      = dbgm_reg && mask_reg[idx_reg];
    wire [31:0] plen      = (ended_reg[idx_reg] && end_reg[idx_reg] >= start_reg[idx_reg]) ?
                            end_reg[idx_reg] - start_reg[idx_reg] : 32'h0;
    wire        push_char = step && accept && !dbgm_reg;
    wire        push_tp   = ce && test_reg && tp_reg && !reply_reg;
    wire        fin_valid = reply_reg || push_char || push_tp;
    wire [7:0]  fin_data  = reply_reg ? bell_pkg::HOST_QUERY :
                            push_tp ? map_char(tp_idx_reg) : map_char(idx_reg);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg    <= '0;
            prev_reg   <= 16'hFFFF;
            ended_reg  <= '0;
            tp_reg     <= 1'b0;
            tp_idx_reg <= '0;
            for (int i = 0; i < bell_pkg::NCH; i++) begin
                st_reg[i]    <= bell_pkg::ST_WAIT;
                exp_reg[i]   <= '0;
                start_reg[i] <= '0;
                end_reg[i]   <= '0;
                cnt_reg[i]   <= '0;
            end
        end else if (ce) begin
            tp_reg <= (tp_reg && !push_tp) || (test_reg && ms_tick);
            if (push_tp && fin_ready) tp_idx_reg <= tp_idx_reg + 4'h1;
            if (step) begin
                idx_reg <= (idx_reg >= top) ? 4'h0 : idx_reg + 4'h1;
                prev_reg[idx_reg] <= lvl;
                if (!on) begin
                    st_reg[idx_reg] <= bell_pkg::ST_DIS;
                end else begin
                    case (cur)
                        bell_pkg::ST_WAIT: begin
                            if (fall) begin
                                exp_reg[idx_reg]   <= us_reg + deb_us;
                                start_reg[idx_reg] <= us_reg;
                                st_reg[idx_reg]    <= bell_pkg::ST_DEB;
                            end
                        end
                        bell_pkg::ST_DEB: begin
                            if (misfire) begin
                                st_reg[idx_reg] <= bell_pkg::ST_WAIT;
                            end else if (accept) begin
                                exp_reg[idx_reg]   <= ms_reg + guard_ms;
                                cnt_reg[idx_reg]   <= 8'h1;
                                ended_reg[idx_reg] <= 1'b0;
                                st_reg[idx_reg]    <= bell_pkg::ST_GUARD;
                            end
                        end
                        bell_pkg::ST_GUARD: begin
                            if (lvl && !ended_reg[idx_reg]) begin
                                end_reg[idx_reg]   <= us_reg;
                                ended_reg[idx_reg] <= 1'b1;
                            end
                            if (fall) cnt_reg[idx_reg] <= cnt_reg[idx_reg] + 8'h1;
                            if (guard_done) st_reg[idx_reg] <= bell_pkg::ST_WAIT;
                        end
                        bell_pkg::ST_DIS: st_reg[idx_reg] <= bell_pkg::ST_WAIT;
                        default: st_reg[idx_reg] <= bell_pkg::ST_WAIT;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug reports and indicator.
    wire rep_s = step && g_exit && dsel && flags_reg[bell_pkg::FLAG_PULSE];
    wire rep_m = step && misfire && dsel && flags_reg[bell_pkg::FLAG_MISFIRE];
    wire rep_d = step && accept && dsel && flags_reg[bell_pkg::FLAG_DEBOUNCE];
    wire led_ch = idx_reg == 4'h0 || (flags_reg[bell_pkg::FLAG_LED] && mask_reg[idx_reg]);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dbg_valid <= 1'b0;
            dbg_kind  <= '0;
            dbg_chan  <= '0;
            dbg_char  <= '0;
            dbg_time  <= '0;
            dbg_len   <= '0;
            dbg_count <= '0;
            indicator <= 1'b0;
            nv_save   <= 1'b0;
        end else if (ce) begin
            dbg_valid <= rep_s || rep_m || rep_d;
            dbg_kind  <= rep_s ? bell_pkg::KIND_S : rep_m ? bell_pkg::KIND_M : bell_pkg::KIND_D;
            dbg_chan  <= 5'(idx_reg) + 5'h1;
            dbg_char  <= map_char(idx_reg);
            dbg_time  <= exp_cur;
            dbg_len   <= rep_m ? us_reg - start_reg[idx_reg] : plen;
            dbg_count <= cnt_reg[idx_reg];
            indicator <= (step && accept && led_ch) || cmd_valid || cmd_error;
            nv_save   <= save_cmd && dbgm_reg && init_reg;
        end
    end
    assign nv_mask_out = mask_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Received byte handler.
    bell_pkg::rx_state_t rx_reg;
    logic [3:0]  rxn_reg;
    logic [7:0]  first_reg;
    logic [31:0] rxt_reg;
    wire rx_to = rxt_reg >= 32'(RXT_CYC - 1);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_reg    <= bell_pkg::RX_IDLE;
            rxn_reg   <= '0;
            first_reg <= '0;
            rxt_reg   <= '0;
            reply_reg <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_byte  <= '0;
        end else if (ce) begin
            cmd_valid <= 1'b0;
            if (reply_reg && fin_ready) reply_reg <= 1'b0;
            case (rx_reg)
                bell_pkg::RX_IDLE: begin
                    if (rx_valid && rx_data == bell_pkg::HOST_QUERY) begin
                        reply_reg <= 1'b1;
                    end else if (rx_valid && rx_data != bell_pkg::HOST_IGNORE) begin
                        first_reg <= rx_data;
                        rxn_reg   <= 4'h1;
                        rxt_reg   <= '0;
                        rx_reg    <= bell_pkg::RX_COLL;
                    end
                end
                bell_pkg::RX_COLL: begin
                    rxt_reg <= rxt_reg + 32'h1;
                    if (rx_valid && rxn_reg == bell_pkg::RX_SET_LAST) begin
                        cmd_valid <= rx_data != bell_pkg::DELAY_TERM;
                        cmd_byte  <= first_reg;
                        rx_reg    <= bell_pkg::RX_IDLE;
                    end else if (rx_valid) begin
                        rxn_reg <= rxn_reg + 4'h1;
                    end else if (rx_to) begin
                        cmd_valid <= 1'b1;
                        cmd_byte  <= first_reg;
                        rx_reg    <= bell_pkg::RX_IDLE;
                    end
                end
                default: rx_reg <= bell_pkg::RX_IDLE;
            endcase
        end
    end

    byte_fifo #(.W(bell_pkg::FIFO_W), .D(bell_pkg::FIFO_D)) out_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (fin_valid),
        .in_data   (fin_data),
        .in_ready  (fin_ready),
        .out_valid (tx_valid),
        .out_data  (tx_data),
        .out_ready (tx_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_wait_arm: assert property (@(posedge clock) disable iff (!rst_n)
        step && on && cur == bell_pkg::ST_WAIT && fall |=> st_reg[$past(idx_reg)] == bell_pkg::ST_DEB)
        else $error("edge did not arm debounce");
    a_char_push: assert property (@(posedge clock) disable iff (!rst_n)
        step && accept && !dbgm_reg |-> fin_valid && fin_data == map_char(idx_reg))
        else $error("accepted pulse sent no character");
    a_guard_exit: assert property (@(posedge clock) disable iff (!rst_n)
        step && g_exit |=> st_reg[$past(idx_reg)] == bell_pkg::ST_WAIT)
        else $error("guard did not end at expiry");
    a_misfire_back: assert property (@(posedge clock) disable iff (!rst_n)
        step && misfire |=> st_reg[$past(idx_reg)] == bell_pkg::ST_WAIT)
        else $error("misfire not returned to waiting");
    a_disabled_chan: assert property (@(posedge clock) disable iff (!rst_n)
        step && !on |=> st_reg[$past(idx_reg)] == bell_pkg::ST_DIS)
        else $error("disabled channel changed state");
    a_scan_order: assert property (@(posedge clock) disable iff (!rst_n)
        step |=> idx_reg == (($past(idx_reg) >= $past(top)) ? 4'h0 : $past(idx_reg) + 4'h1))
        else $error("scan order wrong");
    a_debug_mute: assert property (@(posedge clock) disable iff (!rst_n)
        dbgm_reg && !test_reg && !reply_reg |-> !fin_valid)
        else $error("character sent in debug mode");
    a_query_reply: assert property (@(posedge clock) disable iff (!rst_n)
        ce && rx_reg == bell_pkg::RX_IDLE && rx_valid && rx_data == bell_pkg::HOST_QUERY |=> reply_reg)
        else $error("host query not answered");
    a_test_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        test_reg |-> !step ##1 test_reg)
        else $error("sensors scanned in test mode");
endmodule

// *** host_pc_model.sv ***
`timescale 1ns/1ns
// Stands in for the host PC: takes characters and sends command bytes.
module host_pc_model (
    input  wire logic       clock,
    input  wire logic       stall,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output int              got_count,
    output logic [7:0]      got_last
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        got_count = 0;
        got_last = 8'h00;
    end
    assign tx_ready = !stall;
    always @(posedge clock) begin
        if (tx_valid && tx_ready) begin
            got_count <= got_count + 1;
            got_last  <= tx_data;
        end
    end
    // Sends one byte as a one-cycle strobe, then shows inverted data.
    task automatic send_byte(input logic [7:0] b);
        @(posedge clock);
        #1;
        rx_valid = 1'b1;
        rx_data = b;
        @(posedge clock);
        #1;
        rx_valid = 1'b0;
        rx_data = ~b;
    endtask
endmodule

// *** bell_sensor_scanner_tb.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module bell_sensor_scanner_tb;
    logic clock = 0, rst_n = 0, stall = 0, cfg_we = 0, dbg_mode = 0, test_cmd = 0, cmd_error = 0;
    logic [15:0] sensor_n = 16'hFFFF;
    logic tx_valid, tx_ready, rx_valid, cmd_valid, indicator, dbg_valid;
    logic [7:0] tx_data, rx_data, cmd_byte, dbg_kind, cmd_seen = 8'h00, kind_seen = 8'h00;
    int fail_count = 0, checks_done = 0, got_count, cmd_count = 0, ind_count = 0, n, ch;
    logic [7:0] got_last;
    logic ce = 1, save_cmd = 0, nv_save;
    logic [15:0] nv_enable = 16'h7FFF, nv_mask = 16'h0000, cfg_enable = 16'h7FFF, cfg_mask = 16'hFFFF, nv_mask_out;
    logic [7:0] cfg_debounce_ms = 8'h00, cfg_guard_cs = 8'h01, dbg_char, dbg_count;
    logic [7:0] char_seen = 8'h00, cnt_seen = 8'h00;
    logic [3:0] cfg_flags = 4'h1;
    logic [4:0] dbg_chan, chan_seen = 5'h00;
    logic [31:0] dbg_time, dbg_len, time_seen = 32'h0, len_seen = 32'h0;
    int ev_count = 0, save_count = 0;
    integer seed = 32'h1bcf;
    always #2 clock = ~clock;
    bell_sensor_scanner #(.MS_CYC(50), .RXT_CYC(2000)) dut (.clock(clock), .rst_n(rst_n), .ce(ce),
        .sensor_n(sensor_n), .nv_enable(nv_enable), .nv_mask(nv_mask), .cfg_we(cfg_we),
        .cfg_debounce_ms(cfg_debounce_ms), .cfg_guard_cs(cfg_guard_cs), .cfg_enable(cfg_enable),
        .cfg_debug_mode(dbg_mode), .cfg_flags(cfg_flags), .cfg_mask(cfg_mask), .test_cmd(test_cmd),
        .save_cmd(save_cmd), .cmd_error(cmd_error),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .nv_save(nv_save), .nv_mask_out(nv_mask_out),
        .indicator(indicator), .dbg_valid(dbg_valid), .dbg_kind(dbg_kind), .dbg_chan(dbg_chan),
        .dbg_char(dbg_char), .dbg_time(dbg_time), .dbg_len(dbg_len), .dbg_count(dbg_count));
    host_pc_model pc (.clock(clock), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .got_count(got_count),
        .got_last(got_last));
    always @(posedge clock) begin
        #1;
        stall = ($random(seed) & 3) == 0;
    end
    always @(posedge clock) begin
        if (cmd_valid === 1'b1) begin
            cmd_count <= cmd_count + 1;
            cmd_seen  <= cmd_byte;
        end
        if (dbg_valid === 1'b1) begin
            ev_count  <= ev_count + 1;
            kind_seen <= dbg_kind;
            chan_seen <= dbg_chan;
            char_seen <= dbg_char;
            time_seen <= dbg_time;
            len_seen  <= dbg_len;
            cnt_seen  <= dbg_count;
        end
        if (nv_save === 1'b1) save_count <= save_count + 1;
        if (indicator === 1'b1) ind_count <= ind_count + 1;
    end
    function automatic logic [7:0] chr(input int i);
        string s = "1234567890ETABCD";
        return s[i];
    endfunction
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    // Drives a low pulse with a short bounce at its end, then waits out the guard.
    task automatic pulse(input int c);
        sensor_n[c] = 1'b0;
        tick(60);
        sensor_n[c] = 1'b1;
        tick(20);
        sensor_n[c] = 1'b0;
        tick(20);
        sensor_n[c] = 1'b1;
        tick(700);
    endtask
    task automatic configure(input logic dm);
        dbg_mode = dm;
        cfg_we = 1'b1;
        tick(1);
        cfg_we = 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        complete_run;
    end
    initial begin
        tick(20);
        nv_mask = 16'($random(seed));
        rst_n = 1'b1;
        tick(3);
        `CHK("mask load", nv_mask, nv_mask_out)
        configure(1'b0);
        for (int i = 0; i < 8; i++) begin
            ch = (i == 0) ? 0 : (i == 1) ? 14 : ($random(seed) & 32'h7FFFFFFF) % 15;
            n = got_count;
            pulse(ch);
            `CHK("char count", n + 1, got_count)
            `CHK("char", chr(ch), got_last)
        end
        `CHK("indicator", 1, ind_count > 0)
        n = got_count;
        pulse(15);
        `CHK("disabled", n, got_count)
        cfg_flags = 4'h7;
        cfg_mask = 16'($random(seed)) | 16'h0028;
        configure(1'b1);
        `CHK("mask set", cfg_mask, nv_mask_out)
        sensor_n[5] = 1'b0;
        tick(15);
        sensor_n[5] = 1'b1;
        tick(40);
        `CHK("misfire kind", bell_pkg::KIND_M, kind_seen)
        pulse(3);
        `CHK("debug quiet", n, got_count)
        `CHK("debug kind", bell_pkg::KIND_S, kind_seen)
        `CHK("debug lines", 3, ev_count)
        `CHK("debug chan", 5'd4, chan_seen)
        `CHK("debug char", chr(3), char_seen)
        `CHK("debug pulses", 8'd2, cnt_seen)
        `CHK("debug len", 1, len_seen <= 8)
        `CHK("debug time", 1, time_seen > 10)
        save_cmd = 1'b1;
        tick(1);
        save_cmd = 1'b0;
        configure(1'b0);
        save_cmd = 1'b1;
        tick(1);
        save_cmd = 1'b0;
        tick(2);
        `CHK("saves", 1, save_count)
        pc.send_byte(bell_pkg::HOST_QUERY);
        tick(60);
        `CHK("query reply", bell_pkg::HOST_QUERY, got_last)
        `CHK("reply count", n + 1, got_count)
        pc.send_byte(bell_pkg::HOST_IGNORE);
        tick(60);
        `CHK("ignored", n + 1, got_count)
        pc.send_byte(8'h41);
        tick(2100);
        `CHK("cmd byte", 8'h41, cmd_seen)
        for (int j = 0; j < 2; j++) begin
            n = cmd_count;
            pc.send_byte(8'h42 + j);
            for (int i = 0; i < 11; i++) pc.send_byte($random(seed));
            pc.send_byte(j ? 8'h7E : bell_pkg::DELAY_TERM);
            tick(60);
            `CHK("delay set count", n + j, cmd_count)
        end
        `CHK("bad term byte", 8'h43, cmd_seen)
        n = ind_count;
        cmd_error = 1'b1;
        tick(1);
        cmd_error = 1'b0;
        tick(3);
        `CHK("error indicator", n + 1, ind_count)
        n = got_count;
        test_cmd = 1'b1;
        tick(1);
        test_cmd = 1'b0;
        sensor_n = 16'h0000;
        tick(300);
        `CHK("test chars", 1, got_count > n + 2)
        complete_run;
    end
endmodule
